/* File: verilog/spi_master_slave_port.sv */
// full-duplex byte serial port, master or slave, with apb registers
// How it works
// - select seen low while master sets the mode-fault flag.
// - one byte out and one in per transfer; one done flag.
// - reads come from receive buffer; write during transfer sets collision.
// - master clock idles until data write, then exactly eight cycles.
// - slave shifts eight bits while selected, then copies to buffer.
// - slave write loads shifter, shifted out only on master clocks.
// - control holds interrupt enable, system enable, role select.
// - polarity bit sets the idle clock level, acts as inverter.
// - phase 0: select low starts, first clock edge samples.
// - phase 1: select only enables output; edges set timing.
// - master rate select divides bus clock by 2, 4, 16, 32.
// - done flag set at byte end; interrupt when enabled.
// - done and collision clear by status read then data access.
// - data writes ignored while done set until status read.
// - slave collision window: phase 0 select low, phase 1 first edge to done; master: whole shift state.
// - status bit 5 and bits 3 to 0 read zero.
// - mode fault clears system enable and master select.
// - mode fault clears by status read then control write.
// - data write starts a transfer only in a master.
// - received byte is dropped when done still set.
// - bytes travel most significant bit first.
// - unselected slave leaves its data output undriven.
// - master presents each bit half a period before latch edge.
`include "spi_port_defines.svh"
module spi_master_slave_port
    import spi_port_pkg::*;
(
    input  wire logic        pclk,      // bus clock, 40 MHz
    input  wire logic        presetn,   // async reset, active low
    input  wire logic        psel,      // apb select
    input  wire logic        penable,   // apb access phase
    input  wire logic        pwrite,    // apb direction
    input  wire logic [7:0]  paddr,     // apb byte address
    input  wire logic [31:0] pwdata,    // apb write data
    output logic      [31:0] prdata,    // apb read data
    output logic             pready,    // apb ready
    output logic             pslverr,   // apb error, unmapped address
    output logic             irq_req,   // interrupt request, level
    input  wire logic        sck_in,    // serial clock pin level
    output logic             sck_out,   // serial clock drive value
    output logic             sck_oe,    // serial clock drive enable
    input  wire logic        mosi_in,   // master-out line level
    output logic             mosi_out,  // master-out drive value
    output logic             mosi_oe,   // master-out drive enable
    input  wire logic        miso_in,   // master-in line level
    output logic             miso_out,  // master-in drive value
    output logic             miso_oe,   // master-in drive enable
    input  wire logic        ss_n_in    // slave select pin, active low
);
    rate_if rif ();

    // control register state
    logic       ie_q, en_q, mst_q, clock_idle_polarity_q, clock_sample_phase_q;
    rate_t      rate_q;
    // status flags and their clear-arming bits
    logic       done_q, write_collision_flag_q, mode_fault_flag_q;
    logic       done_arm_q, write_collision_flag_arm_q, mode_fault_flag_arm_q;
    // shifter state
    byte_t      sh_q, rx_q;
    logic       samp_q, out_q, sck_ph_q, sck_prev_q, sact_q;
    logic [3:0] edge_q;
    mst_state_t state_q, state_d;
    logic [31:0] prdata_q;

    // apb decode
    logic setup_w, acc_w, hit_ctl, hit_st, hit_dat, mapped_w;
    logic wr_ctl, wr_dat, rd_st, acc_dat;
    assign setup_w  = psel && !penable;
    assign acc_w    = psel && penable;
    assign hit_ctl  = (paddr == `CTL_OFF);
    assign hit_st   = (paddr == `STAT_OFF);
    assign hit_dat  = (paddr == `DATA_OFF);
    assign mapped_w = hit_ctl || hit_st || hit_dat;
    assign wr_ctl   = acc_w && pwrite && hit_ctl;
    assign wr_dat   = acc_w && pwrite && hit_dat;
    assign rd_st    = acc_w && !pwrite && hit_st;
    assign acc_dat  = acc_w && hit_dat;
    assign pready   = 1'b1;
    assign pslverr  = acc_w && !mapped_w;
    assign prdata   = prdata_q;

    // register images as software sees them
    byte_t ctl_w, st_w;
    assign ctl_w = {ie_q, en_q, 1'b0, mst_q, clock_idle_polarity_q, clock_sample_phase_q, rate_q};
    assign st_w  = {done_q, write_collision_flag_q, 1'b0, mode_fault_flag_q, 4'h0};

    // read mux for one mapped word
    function automatic byte_t rd_mux(input logic c, input logic s, input logic d,
                                     input byte_t cv, input byte_t sv, input byte_t dv);
        rd_mux = c ? cv : (s ? sv : (d ? dv : 8'h00));
    endfunction : rd_mux

    // role and selection
    logic is_mst, sel_w, mfault;
    assign is_mst = en_q && mst_q;
    assign sel_w  = en_q && !mst_q && !ss_n_in;
    assign mfault = is_mst && !ss_n_in;

    // slave clock edges, polarity folded in as an inverter
    logic sck_n, s_lead, s_trail;
    assign sck_n   = sck_in ^ clock_idle_polarity_q;
    assign s_lead  = sel_w && sck_n && !sck_prev_q;
    assign s_trail = sel_w && !sck_n && sck_prev_q;

    // master clock edges from the divider
    logic m_tick, m_lead, m_trail, lead_w, trail_w, fin_w;
    assign m_tick  = rif.tick && (state_q == MS_SHIFT);
    assign m_lead  = m_tick && !sck_ph_q;
    assign m_trail = m_tick && sck_ph_q;
    assign lead_w  = is_mst ? m_lead : s_lead;
    assign trail_w = is_mst ? m_trail : s_trail;
    assign fin_w   = trail_w && (edge_q == `LAST_EDGE);

    // incoming bit and assembled byte, msb first
    logic din_w;
    byte_t new_byte;
    assign din_w    = is_mst ? miso_in : mosi_in;
    assign new_byte = {sh_q[6:0], clock_sample_phase_q ? din_w : samp_q};

    // transfer window for collision detection
    logic busy_w;
    assign busy_w = is_mst ? (state_q == MS_SHIFT)
                  : (clock_sample_phase_q ? sact_q : sel_w);

    // data write acceptance
    logic wr_ok, col_w, load_w, start_w;
    assign wr_ok   = wr_dat && !(done_q && !done_arm_q);
    assign col_w   = wr_ok && busy_w;
    assign load_w  = wr_ok && !busy_w;
    assign start_w = load_w && is_mst;

    // divider hookup
    assign rif.run  = (state_q == MS_SHIFT);
    assign rif.rate = rate_q;

    rate_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .rif     (rif)
    );

    // pin drive: phase 0 presents the msb at once, phase 1 at lead edge
    logic dout_w;
    assign dout_w   = clock_sample_phase_q ? out_q : sh_q[7];
    assign sck_out  = clock_idle_polarity_q ^ sck_ph_q;
    assign sck_oe   = is_mst;
    assign mosi_out = dout_w;
    assign mosi_oe  = is_mst;
    assign miso_out = dout_w;
    assign miso_oe  = sel_w;
    assign irq_req  = ie_q && (done_q || mode_fault_flag_q);

    // master sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            MS_IDLE: begin
                if (start_w) begin
                    state_d = MS_SHIFT;
                end
            end
            MS_SHIFT: begin
                if (fin_w || !is_mst) begin
                    state_d = MS_IDLE;
                end
            end
            default: state_d = MS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= MS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // control register; mode fault forces slave and disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ie_q, en_q, mst_q, clock_idle_polarity_q, clock_sample_phase_q, rate_q} <= 7'h00;
        end else begin
            if (wr_ctl) begin
                ie_q   <= pwdata[`CTL_IE];
                en_q   <= pwdata[`CTL_EN];
                mst_q  <= pwdata[`CTL_MST];
                clock_idle_polarity_q <= pwdata[`CTL_CLOCK_IDLE_POLARITY];
                clock_sample_phase_q <= pwdata[`CTL_CLOCK_SAMPLE_PHASE];
                rate_q <= pwdata[`CTL_RATE_HI:`CTL_RATE_LO];
            end
            if (mfault) begin
                en_q  <= 1'b0;
                mst_q <= 1'b0;
            end
        end
    end

    // read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (setup_w && !pwrite) begin
            prdata_q <= {24'h0, rd_mux(hit_ctl, hit_st, hit_dat, ctl_w, st_w, rx_q)};
        end
    end

    // done flag: set wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q     <= 1'b0;
            done_arm_q <= 1'b0;
        end else begin
            done_q     <= fin_w || (done_q && !(done_arm_q && acc_dat));
            done_arm_q <= done_q && ((rd_st && prdata_q[`ST_DONE])
                          || (done_arm_q && !acc_dat));
        end
    end

    // collision flag: set wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_collision_flag_q     <= 1'b0;
            write_collision_flag_arm_q <= 1'b0;
        end else begin
            write_collision_flag_q     <= col_w || (write_collision_flag_q && !(write_collision_flag_arm_q && acc_dat));
            write_collision_flag_arm_q <= write_collision_flag_q && ((rd_st && prdata_q[`ST_WRITE_COLLISION_FLAG])
                          || (write_collision_flag_arm_q && !acc_dat));
        end
    end

    // mode fault flag, cleared by status read then control write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_fault_flag_q     <= 1'b0;
            mode_fault_flag_arm_q <= 1'b0;
        end else begin
            mode_fault_flag_q     <= mfault || (mode_fault_flag_q && !(mode_fault_flag_arm_q && wr_ctl));
            mode_fault_flag_arm_q <= mode_fault_flag_q && ((rd_st && prdata_q[`ST_MODE_FAULT_FLAG])
                          || (mode_fault_flag_arm_q && !wr_ctl));
        end
    end

    // receive buffer, newer byte lost on overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= `BYTE_RST;
        end else if (fin_w && !done_q) begin
            rx_q <= new_byte;
        end
    end

    // shift register: write loads, trail edge shifts in
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= `BYTE_RST;
        end else if (load_w) begin
            sh_q <= pwdata[7:0];
        end else if (trail_w) begin
            sh_q <= new_byte;
        end
    end

    // phase 0 latches on lead edge; phase 1 presents on lead edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_q <= 1'b0;
            out_q  <= 1'b0;
        end else if (lead_w) begin
            samp_q <= din_w;
            out_q  <= sh_q[7];
        end
    end

    // edge counter; phase 0 slave restarts on select high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_q <= 4'h0;
        end else if (!en_q || start_w || (!is_mst && !clock_sample_phase_q && ss_n_in)) begin
            edge_q <= 4'h0;
        end else if (lead_w || trail_w) begin
            edge_q <= edge_q + 4'h1;
        end
    end

    // master clock phase and slave edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_ph_q   <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_ph_q   <= (state_q == MS_SHIFT) && (sck_ph_q ^ m_tick);
            sck_prev_q <= sck_n;
        end
    end

    // phase 1 slave transfer window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sact_q <= 1'b0;
        end else if (fin_w || !sel_w) begin
            sact_q <= 1'b0;
        end else if (s_lead && clock_sample_phase_q) begin
            sact_q <= 1'b1;
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [4:0] tog_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_q <= 5'h0;
        end else if (start_w) begin
            tog_q <= 5'h0;
        end else if (m_tick) begin
            tog_q <= tog_q + 5'h1;
        end
    end

    sck_idle_a: assert property (is_mst && state_q == MS_IDLE |-> sck_out == clock_idle_polarity_q)
        else $error("master clock not at idle level");
    eight_clk_a: assert property (is_mst && fin_w |=> tog_q == 5'h10 && sck_out == clock_idle_polarity_q)
        else $error("master byte not sixteen clock edges");
    mode_fault_flag_set_a: assert property (mfault |=> mode_fault_flag_q && !en_q && !mst_q)
        else $error("mode fault not taken");
    stat_zero_a: assert property (acc_w && !pwrite && hit_st |-> prdata[5] == 1'b0
                                  && prdata[3:0] == 4'h0)
        else $error("unimplemented status bits not zero");
    write_collision_flag_set_a: assert property (col_w |=> write_collision_flag_q
                                 && sh_q == $past(trail_w ? new_byte : sh_q))
        else $error("collision write not flagged");
    slave_load_a: assert property (load_w && !is_mst |=> state_q == MS_IDLE
                                   && sh_q == $past(pwdata[7:0]))
        else $error("slave write started a transfer");
    overrun_a: assert property (fin_w && done_q |=> $stable(rx_q))
        else $error("overrun byte kept");
    done_clr_a: assert property ($fell(done_q) |-> $past(done_arm_q) && $past(acc_dat))
        else $error("done cleared without sequence");
    wr_block_a: assert property (wr_dat && done_q && !done_arm_q |=>
                                 sh_q == $past(trail_w ? new_byte : sh_q))
        else $error("blocked data write took effect");
    miso_off_a: assert property (ss_n_in || mst_q |-> !miso_oe)
        else $error("unselected slave drives data");
    irq_done_a: assert property ($rose(done_q) && ie_q |-> irq_req)
        else $error("no interrupt on done");

    m_xfer_c: cover property (is_mst && fin_w);
    s_xfer_c: cover property (!is_mst && fin_w);
    mode_fault_flag_c:   cover property (mfault);
    write_collision_flag_c:   cover property (col_w);
endmodule : spi_master_slave_port

/* File: verilog/spi_port_defines.svh */
// offsets, field positions, reset values and rate constants of the serial port
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// register byte addresses
`define CTL_OFF      8'h00
`define STAT_OFF     8'h04
`define DATA_OFF     8'h0c

// control register fields
`define CTL_IE       7
`define CTL_EN       6
`define CTL_MST      4
`define CTL_CLOCK_IDLE_POLARITY     3
`define CTL_CLOCK_SAMPLE_PHASE     2
`define CTL_RATE_HI  1
`define CTL_RATE_LO  0

// status register fields
`define ST_DONE      7
`define ST_WRITE_COLLISION_FLAG      6
`define ST_MODE_FAULT_FLAG      4

// reset values
`define CTL_RST      8'h00
`define BYTE_RST     8'h00

// bus clock divide ratios per rate select code
`define DIV_RATE0    6'h02
`define DIV_RATE1    6'h04
`define DIV_RATE2    6'h10
`define DIV_RATE3    6'h20

// last edge index of a byte (sixteen clock edges)
`define LAST_EDGE    4'hf

`endif

/* File: verilog/spi_port_pkg.sv */
// types shared by the serial port modules
package spi_port_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] rate_t;
    typedef enum logic {MS_IDLE, MS_SHIFT} mst_state_t;
endpackage : spi_port_pkg

/* File: verilog/rate_if.sv */
// carrier between the port logic and its bit-rate divider
interface rate_if;
    import spi_port_pkg::*;
    logic  run;   // divider counts while high
    rate_t rate;  // rate select code
    logic  tick;  // one-cycle half-period enable
    modport ctl (output run, output rate, input tick);
    modport div (input run, input rate, output tick);
endinterface : rate_if

/* File: verilog/rate_divider.sv */
// half-period enable generator for the master serial clock
`include "spi_port_defines.svh"
module rate_divider
    import spi_port_pkg::*;
(
    input  wire logic pclk,     // bus clock
    input  wire logic presetn,  // async reset, active low
    rate_if.div       rif       // run, rate and tick
);
    logic [3:0] cnt_q;
    logic [3:0] half_w;

    // last count of a half period of the selected divide ratio, in bus cycles
    function automatic logic [3:0] half_of(input rate_t r);
        logic [5:0] d;
        logic [4:0] h;
        d = `DIV_RATE0;
        case (r)
            2'h0:    d = `DIV_RATE0;
            2'h1:    d = `DIV_RATE1;
            2'h2:    d = `DIV_RATE2;
            default: d = `DIV_RATE3;
        endcase
        h = d[5:1];
        half_of = 4'(h - 5'h01);
    endfunction : half_of

    // terminal count marks each half period; the divide-by-32 terminal count of 15 fits in four bits
    assign half_w   = half_of(rif.rate);
    assign rif.tick = rif.run && (cnt_q == half_w);

    // counter restarts whenever the shifter is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else if (!rif.run || rif.tick) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : rate_divider

/* File: verif/spi_far_end.sv */
// far-end serial device model: master or slave facing the port pins
module spi_far_end
    import spi_port_pkg::*;
(
    input  wire logic pclk,     // bus clock, paces the far master
    input  wire logic sck_w,    // resolved serial clock
    input  wire logic mosi_w,   // resolved master-out line
    input  wire logic miso_w,   // resolved master-in line
    output logic      sck_drv,  // far master clock value
    output logic      sck_en,   // far master clock enable
    output logic      mosi_drv, // far master data value
    output logic      mosi_en,  // far master data enable
    output logic      miso_drv, // far slave data value
    output logic      miso_en,  // far slave data enable
    output logic      ss_n      // select to the port, active low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic  clock_idle_polarity, clock_sample_phase; // shared clock mode
    byte_t sh, rx;     // outgoing and received bytes
    int    nbit;       // bits sampled by the far slave

    initial begin
        {clock_idle_polarity, clock_sample_phase, sck_drv, sck_en, mosi_drv, mosi_en, miso_drv, miso_en} = '0;
        ss_n = 1'b1;
        nbit = 0;
    end

    // choose clock mode and role; the far master clock stands at idle level
    task automatic setup(input logic p, input logic h, input logic m);
        clock_idle_polarity = p;
        clock_sample_phase = h;
        sck_en <= m;
        sck_drv <= p;
        miso_en <= 1'b0;
    endtask : setup

    // drive the select line alone, used to provoke a mode fault
    task automatic select(input logic v);
        ss_n <= v;
    endtask : select

    // far slave: arm with a byte; phase 0 shows the msb at once
    task automatic load(input byte_t b);
        sh = b;
        nbit = 0;
        miso_en <= 1'b1;
        if (!clock_sample_phase) begin
            miso_drv <= sh[7];
            sh = sh << 1;
        end
    endtask : load

    // far slave follows the wire edges, releasing its line after eight bits
    always @(sck_w) begin
        if (miso_en && !sck_en) begin
            if ((sck_w !== clock_idle_polarity) == !clock_sample_phase) begin
                rx = {rx[6:0], mosi_w};
                nbit++;
                if (nbit == 8)
                    miso_en <= 1'b0;
            end else begin
                miso_drv <= sh[7];
                sh = sh << 1;
            end
        end
    end

    // one half period of the far master clock: present or sample a bit
    task automatic half(input logic lead, input int hp);
        repeat (hp) @(posedge pclk);
        sck_drv <= lead ? ~clock_idle_polarity : clock_idle_polarity;
        if (lead == clock_sample_phase) begin
            mosi_drv <= sh[7];
            sh = sh << 1;
        end else
            rx = {rx[6:0], miso_w};
    endtask : half

    // far master: one byte with select low throughout, high again afterwards
    task automatic send(input byte_t b, input int hp);
        sh = b;
        ss_n <= 1'b0;
        mosi_en <= 1'b1;
        if (!clock_sample_phase) begin
            mosi_drv <= sh[7];
            sh = sh << 1;
        end
        repeat (8) begin
            half(1'b1, hp);
            half(1'b0, hp);
        end
        repeat (hp) @(posedge pclk);
        ss_n <= 1'b1;
        mosi_en <= 1'b0;
        repeat (hp) @(posedge pclk);
    endtask : send
endmodule : spi_far_end

/* File: verif/spi_master_slave_port_test.sv */
// self-checking bench for the serial port: registers, master, slave, faults
`include "spi_port_defines.svh"
module spi_master_slave_port_test
    import spi_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam byte_t IE = 8'h01 << `CTL_IE;
    localparam byte_t EN = 8'h01 << `CTL_EN;
    localparam byte_t MS = 8'h01 << `CTL_MST;
    localparam byte_t PO = 8'h01 << `CTL_CLOCK_IDLE_POLARITY;
    localparam byte_t PH = 8'h01 << `CTL_CLOCK_SAMPLE_PHASE;
    localparam byte_t DN = 8'h01 << `ST_DONE;
    localparam byte_t WC = 8'h01 << `ST_WRITE_COLLISION_FLAG;
    localparam byte_t MF = 8'h01 << `ST_MODE_FAULT_FLAG;
    localparam int    DIV [4] = '{2, 4, 16, 32};
    logic        pclk = 1'b0, presetn = 1'b0, flip = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic        pready, pslverr, irq_req, sck_out, sck_oe, mosi_out, mosi_oe;
    logic        miso_out, miso_oe, sck_w, mosi_w, miso_w, ss_n;
    logic        f_sck, f_sck_en, f_mosi, f_mosi_en, f_miso, f_miso_en;
    int          error_cnt = 0, checks = 0, edges = 0;

    always #12.5 pclk = ~pclk;
    // undriven lines show a pattern that changes every cycle
    always @(posedge pclk) flip <= ~flip;
    assign sck_w  = sck_oe ? sck_out : (f_sck_en ? f_sck : flip);
    assign mosi_w = mosi_oe ? mosi_out : (f_mosi_en ? f_mosi : flip);
    assign miso_w = miso_oe ? miso_out : (f_miso_en ? f_miso : flip);
    always @(sck_w) if (sck_oe) edges++;

    spi_master_slave_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq_req, .sck_in(sck_w), .sck_out,
        .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out,
        .miso_oe, .ss_n_in(ss_n));
    spi_far_end far (.pclk, .sck_w, .mosi_w, .miso_w, .sck_drv(f_sck), .sck_en(f_sck_en),
        .mosi_drv(f_mosi), .mosi_en(f_mosi_en), .miso_drv(f_miso), .miso_en(f_miso_en),
        .ss_n);

    task automatic results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer: setup, access until pready, then an idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input byte_t d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20) begin
            error_cnt++;
            results();
        end
    endtask : apb

    // cycles after the idle cycle of a data write until the interrupt rises
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (irq_req !== 1'b1 && n < 2000);
        @(posedge pclk);
        if (n >= 2000) begin
            error_cnt++;
            results();
        end
    endtask : wait_irq

    // reset values, a control round trip, read-only status, an unmapped word
    task automatic t_reset;
        apb(1'b0, `STAT_OFF, 8'h00);
        chk(rdv, 32'h0);
        apb(1'b1, `CTL_OFF, IE | PO | PH | 8'h03);
        apb(1'b0, `CTL_OFF, 8'h00);
        chk(rdv, IE | PO | PH | 8'h03);
        chk(rerr, 1'b0);
        apb(1'b1, `STAT_OFF, 8'hff);
        apb(1'b0, `STAT_OFF, 8'h00);
        chk(rdv, 32'h0);
        chk(irq_req, 1'b0);
        apb(1'b0, 8'h08, 8'h00);
        chk(rerr, 1'b1);
        $display("test reset done");
    endtask : t_reset

    // one master byte at every rate, each with its own polarity and phase
    task automatic t_master;
        int n;
        byte_t c;
        for (int r = 0; r < 4; r++) begin
            c = EN | MS | IE | byte_t'(r) | (r[0] ? PO : 8'h00) | (r[1] ? PH : 8'h00);
            apb(1'b1, `CTL_OFF, c);
            far.setup(r[0], r[1], 1'b0);
            far.load(8'h5a ^ byte_t'(r));
            edges = 0;
            apb(1'b1, `DATA_OFF, 8'hc3 + byte_t'(r));
            wait_irq(n);
            chk(n, 16 * DIV[r] / 2 - 1);
            chk(edges, 16);
            chk(sck_w, r[0]);
            chk(far.rx, 8'hc3 + r);
            apb(1'b0, `STAT_OFF, 8'h00);
            chk(rdv, DN);
            apb(1'b0, `DATA_OFF, 8'h00);
            chk(rdv, 8'h5a ^ r);
        end
        apb(1'b0, `STAT_OFF, 8'h00);
        chk(rdv, 32'h0);
        $display("test master done");
    endtask : t_master

    // a write mid-byte collides; a write with done still unseen is ignored
    task automatic t_collide;
        int n;
        apb(1'b1, `CTL_OFF, IE | EN | MS | 8'h03);
        far.setup(1'b0, 1'b0, 1'b0);
        far.load(8'h96);
        apb(1'b1, `DATA_OFF, 8'h81);
        apb(1'b1, `DATA_OFF, 8'h7e);
        wait_irq(n);
        chk(far.rx, 8'h81);
        edges = 0;
        apb(1'b1, `DATA_OFF, 8'h3c);
        repeat (40) @(posedge pclk);
        chk(edges, 0);
        apb(1'b0, `STAT_OFF, 8'h00);
        chk(rdv, DN | WC);
        apb(1'b0, `DATA_OFF, 8'h00);
        chk(rdv, 8'h96);
        apb(1'b0, `STAT_OFF, 8'h00);
        chk(rdv, 32'h0);
        $display("test collision done");
    endtask : t_collide

    // select pulled low on an enabled master forces slave mode
    task automatic t_fault;
        apb(1'b1, `CTL_OFF, IE | EN | MS);
        far.select(1'b0);
        repeat (4) @(posedge pclk);
        chk(irq_req, 1'b1);
        apb(1'b0, `CTL_OFF, 8'h00);
        chk(rdv, IE);
        apb(1'b0, `STAT_OFF, 8'h00);
        chk(rdv, MF);
        far.select(1'b1);
        apb(1'b1, `CTL_OFF, 8'h00);
        apb(1'b0, `STAT_OFF, 8'h00);
        chk(rdv, 32'h0);
        chk(irq_req, 1'b0);
        $display("test fault done");
    endtask : t_fault

    // slave bytes in both phases, then a second byte while done is still set
    task automatic t_slave;
        for (int h = 0; h < 2; h++) begin
            apb(1'b1, `CTL_OFF, EN | (h[0] ? (PH | PO) : 8'h00));
            far.setup(h[0], h[0], 1'b1);
            apb(1'b1, `DATA_OFF, 8'ha5 ^ byte_t'(h));
            repeat (20) @(posedge pclk);
            chk(miso_oe, 1'b0);
            apb(1'b0, `STAT_OFF, 8'h00);
            chk(rdv, 32'h0);
            far.send(8'h3b + byte_t'(h), 4);
            chk(far.rx, 8'ha5 ^ h);
            far.send(8'hf0, 4);
            apb(1'b0, `STAT_OFF, 8'h00);
            chk(rdv, DN);
            apb(1'b0, `DATA_OFF, 8'h00);
            chk(rdv, 8'h3b + h);
        end
        $display("test slave done");
    endtask : t_slave

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_master();
        t_collide();
        t_fault();
        t_slave();
        results();
    end
endmodule : spi_master_slave_port_test
